// ### ptmr_map.vh
// Purpose: Register map, field layout, reset values and timing counts of the period timer.
// Assumes: Included by bare name into the period timer design files.
// Notes: Definitions only; offsets, reset values, fields and scaler counts live here once.
`ifndef PTMR_MAP_VH
`define PTMR_MAP_VH

// Address decode width and APB data width.
`define PTMR_ADDR_W 12
`define PTMR_DATA_W 32

// Byte offsets of the registers on the APB.
`define PTMR_OFS_COUNT 12'h000
`define PTMR_OFS_CTRL 12'h004
`define PTMR_OFS_PERIOD 12'h008
`define PTMR_OFS_FLAG 12'h00c
`define PTMR_OFS_ENABLE 12'h010

// Reset values.
`define PTMR_RST_COUNT 8'h00
`define PTMR_RST_CTRL 7'h00
`define PTMR_RST_PERIOD 8'hff

// Control register fields.
`define PTMR_CTRL_PRE_LO 0
`define PTMR_CTRL_PRE_HI 1
`define PTMR_CTRL_RUN 2
`define PTMR_CTRL_POST_LO 3
`define PTMR_CTRL_POST_HI 6

// Position of the period flag in the flag and enable registers.
`define PTMR_FLAG_BIT 1

// Prescale select codes and the terminal counts they give.
`define PTMR_PRE_DIV1 2'h0
`define PTMR_PRE_DIV4 2'h1
`define PTMR_PRE_LAST1 4'h0
`define PTMR_PRE_LAST4 4'h3
`define PTMR_PRE_LAST16 4'hf

// The instruction clock is the system clock divided by four.
`define PTMR_INSTR_DIV 4
`define PTMR_INSTR_LAST 2'h3

`endif

// ### ptmr_prescale.v
// Purpose: Instruction clock divider and selectable prescaler for the period timer.
// Assumes: clk is the oscillator clock; clear comes from logic on the same clock.
// Notes: tick is a one-cycle pulse, one per prescaled instruction cycle.
`timescale 1ns/100ps
`default_nettype none
`include "ptmr_map.vh"

module ptmr_prescale (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Control.
  input wire clear,
  input wire [1:0] sel,
  // Prescaled tick.
  output wire tick
);

  reg [1:0] instr_div;
  reg [3:0] pre_cnt;
  wire instr_tick;

  // Maps the select field onto the last count of the prescaler.
  function [3:0] pre_last;
    input [1:0] s;
    begin
      if (s == `PTMR_PRE_DIV1) begin
        pre_last = `PTMR_PRE_LAST1;
      end else if (s == `PTMR_PRE_DIV4) begin
        pre_last = `PTMR_PRE_LAST4;
      end else begin
        pre_last = `PTMR_PRE_LAST16;
      end
    end
  endfunction

  // The instruction phase runs free; clearing it would stretch the machine cycle.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  assign instr_tick = (instr_div == `PTMR_INSTR_LAST);

  // Prescaler counts instruction cycles and restarts on a clear.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= 4'h0; // [RULE_07]
    end else if (clear) begin
      pre_cnt <= 4'h0; // [RULE_07]
    end else if (instr_tick) begin
      if (pre_cnt >= pre_last(sel)) begin
        pre_cnt <= 4'h0; // [RULE_03]
      end else begin
        pre_cnt <= pre_cnt + 4'h1;
      end
    end
  end

  // A tick leaves on the instruction cycle that completes the division.
  assign tick = instr_tick && !clear && (pre_cnt >= pre_last(sel)); // [RULE_03]

endmodule // ptmr_prescale

`default_nettype wire

// ### ptmr_top.v
// Purpose: Eight-bit period timer with prescaler, postscaler and APB registers.
// Assumes: APB master on clk; partner units sample the timer outputs on clk.
// Notes: Every output is a flip-flop; partner pulses lag the match by one cycle.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ptmr_map.vh"

// Functional notes
// RULE_01: Count up from zero, restart after period match.
// RULE_02: Period register resets to FFh, always accessible.
// RULE_03: Prescale select divides by one, four, sixteen.
// RULE_04: Postscaler sets flag every N+1 matches.
// RULE_05: Control layout: postscale, run, prescale; bit7 zero.
// RULE_06: Counter advances only while run bit set.
// RULE_07: Writes to count or control clear scalers.
// RULE_08: Control writes leave the count unchanged.
// RULE_09: Count register read/write, zero on reset.
// RULE_10: Postscaler ratio sets flag at bit one.
// RULE_11: Match pulse before postscaler drives serial clock.
// RULE_12: Count and match feed the PWM time base.
// RULE_13: Flag sticky until cleared; enable gates interrupt.
module ptmr_top (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt request.
  output reg irq,
  // Synchronous serial port shift clock source.
  output reg ssp_shift_clk,
  // PWM time base for the capture/compare unit.
  output reg [7:0] pwm_count,
  output reg pwm_match
);

  // Register select codes, one bit per register.
  localparam SEL_NONE = 5'h00;
  localparam SEL_COUNT = 5'h01;
  localparam SEL_CTRL = 5'h02;
  localparam SEL_PERIOD = 5'h04;
  localparam SEL_FLAG = 5'h08;
  localparam SEL_ENABLE = 5'h10;

  // Software visible state.
  reg [7:0] tick_count;
  reg [7:0] period_match;
  reg [6:0] timer_control;
  reg period_irq_flag;
  reg period_irq_enable;

  // Postscaler state.
  reg [3:0] post_cnt;

  // Derived control and events.
  wire [1:0] prescale_select;
  wire [3:0] postscale_select;
  wire run_bit;
  wire pre_tick;
  wire advance;
  wire match;
  wire post_event;

  // Bus decode.
  wire [4:0] sel;
  wire setup_phase;
  wire wr_commit;
  wire wr_count;
  wire wr_ctrl;
  wire wr_period;
  wire wr_flag;
  wire wr_enable;
  wire scaler_clear;

  // Next values.
  reg [7:0] next_tick_count;
  reg [3:0] next_post_cnt;
  reg next_flag;
  reg [31:0] next_prdata;

  // Decodes a byte address into a one-hot register select.
  function [4:0] reg_sel;
    input [11:0] a;
    begin
      case (a)
        `PTMR_OFS_COUNT: begin
          reg_sel = SEL_COUNT;
        end
        `PTMR_OFS_CTRL: begin
          reg_sel = SEL_CTRL;
        end
        `PTMR_OFS_PERIOD: begin
          reg_sel = SEL_PERIOD;
        end
        `PTMR_OFS_FLAG: begin
          reg_sel = SEL_FLAG;
        end
        `PTMR_OFS_ENABLE: begin
          reg_sel = SEL_ENABLE;
        end
        default: begin
          reg_sel = SEL_NONE;
        end
      endcase
    end
  endfunction

  // Places a single flag or enable bit at its documented position.
  function [31:0] flag_word;
    input b;
    begin
      flag_word = 32'h00000000;
      flag_word[`PTMR_FLAG_BIT] = b;
    end
  endfunction

  // Control fields.
  assign prescale_select = timer_control[`PTMR_CTRL_PRE_HI:`PTMR_CTRL_PRE_LO]; // [RULE_05]
  assign postscale_select = timer_control[`PTMR_CTRL_POST_HI:`PTMR_CTRL_POST_LO]; // [RULE_05]
  assign run_bit = timer_control[`PTMR_CTRL_RUN]; // [RULE_05]

  // Bus phases; a write lands only at the access edge where pready is high.
  assign sel = reg_sel(paddr);
  assign setup_phase = psel && !penable;
  assign wr_commit = psel && penable && pready && pwrite;
  assign wr_count = wr_commit && (sel == SEL_COUNT);
  assign wr_ctrl = wr_commit && (sel == SEL_CTRL);
  assign wr_period = wr_commit && (sel == SEL_PERIOD);
  assign wr_flag = wr_commit && (sel == SEL_FLAG);
  assign wr_enable = wr_commit && (sel == SEL_ENABLE);

  // Either timer write restarts both scalers.
  assign scaler_clear = wr_count || wr_ctrl; // [RULE_07]

  // Prescaled instruction clock.
  ptmr_prescale u_prescale (
    .clk(clk),
    .rst(rst),
    .clear(scaler_clear),
    .sel(prescale_select),
    .tick(pre_tick)
  );

  // The counter steps only on a tick while running.
  assign advance = pre_tick && run_bit; // [RULE_06]
  assign match = advance && (tick_count == period_match); // [RULE_01]
  assign post_event = match && (post_cnt == postscale_select); // [RULE_04]

  // Next count; a software write wins over an increment in the same cycle.
  always @* begin
    next_tick_count = tick_count;
    if (wr_count) begin
      next_tick_count = pwdata[7:0]; // [RULE_09]
    end else if (match) begin
      next_tick_count = `PTMR_RST_COUNT; // [RULE_01]
    end else if (advance) begin
      next_tick_count = tick_count + 8'h01; // [RULE_01]
    end
  end

  // Next postscaler count; N+1 matches make one flag event.
  always @* begin
    next_post_cnt = post_cnt;
    if (scaler_clear) begin
      next_post_cnt = 4'h0; // [RULE_07]
    end else if (post_event) begin
      next_post_cnt = 4'h0; // [RULE_04]
    end else if (match) begin
      next_post_cnt = post_cnt + 4'h1; // [RULE_04]
    end
  end

  // Sticky flag; a new event beats a write-one-to-clear in the same cycle.
  always @* begin
    next_flag = period_irq_flag;
    if (post_event) begin
      next_flag = 1'b1; // [RULE_10]
    end else if (wr_flag && pwdata[`PTMR_FLAG_BIT]) begin
      next_flag = 1'b0; // [RULE_13]
    end
  end

  // Counter and postscaler; a control write touches neither count nor period.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_count <= `PTMR_RST_COUNT; // [RULE_09]
      post_cnt <= 4'h0; // [RULE_07]
    end else begin
      tick_count <= next_tick_count; // [RULE_08]
      post_cnt <= next_post_cnt;
    end
  end

  // Period register, reachable at any time, even while counting.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      period_match <= `PTMR_RST_PERIOD; // [RULE_02]
    end else if (wr_period) begin
      period_match <= pwdata[7:0]; // [RULE_02]
    end
  end

  // Control register; bit 7 is not stored and reads as zero.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_control <= `PTMR_RST_CTRL; // [RULE_05]
    end else if (wr_ctrl) begin
      timer_control <= pwdata[6:0]; // [RULE_05]
    end
  end

  // Interrupt flag and its enable.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      period_irq_flag <= 1'b0;
      period_irq_enable <= 1'b0;
    end else begin
      period_irq_flag <= next_flag; // [RULE_13]
      if (wr_enable) begin
        period_irq_enable <= pwdata[`PTMR_FLAG_BIT];
      end
    end
  end

  // The request follows the next flag so that it drops with the clear edge.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (wr_enable) begin
      irq <= next_flag && pwdata[`PTMR_FLAG_BIT]; // [RULE_13]
    end else begin
      irq <= next_flag && period_irq_enable; // [RULE_13]
    end
  end

  // Partner outputs are registered; the pulses come one cycle after the match, pwm_count tracks tick_count.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ssp_shift_clk <= 1'b0;
      pwm_match <= 1'b0;
      pwm_count <= `PTMR_RST_COUNT;
    end else begin
      ssp_shift_clk <= match; // [RULE_11]
      pwm_match <= match; // [RULE_12]
      pwm_count <= next_tick_count; // [RULE_12]
    end
  end

  // Read mux; the value is captured in the setup cycle, so a running count
  // is reported as it stood then, which keeps the bus free of wait states.
  always @* begin
    next_prdata = 32'h00000000;
    case (sel)
      SEL_COUNT: begin
        next_prdata = {24'h000000, tick_count}; // [RULE_09]
      end
      SEL_CTRL: begin
        next_prdata = {25'h0, timer_control}; // [RULE_05]
      end
      SEL_PERIOD: begin
        next_prdata = {24'h000000, period_match}; // [RULE_02]
      end
      SEL_FLAG: begin
        next_prdata = flag_word(period_irq_flag);
      end
      SEL_ENABLE: begin
        next_prdata = flag_word(period_irq_enable);
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // APB answer: ready in the first access cycle, error on an unmapped address.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= (sel == SEL_NONE);
      prdata <= pwrite ? 32'h00000000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

endmodule // ptmr_top

`default_nettype wire

// ### ptmr_top_asserts.sv
// Purpose: Port assertions for the period timer.
// Assumes: Bound to ptmr_top; one clock domain.
// Notes: Pulses are judged against their one-cycle contract.
`timescale 1ns/100ps
`default_nettype none
module ptmr_top_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer outputs.
  input wire logic irq,
  input wire logic ssp_shift_clk,
  input wire logic [7:0] pwm_count,
  input wire logic pwm_match
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus answers come exactly once, right after the setup cycle.
  property p_rdy_next; psel && !penable |=> pready; endproperty
  property p_rdy_once; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  // Both partner pulses are one copy of the same match.
  property p_pair; ssp_shift_clk == pwm_match; endproperty
  property p_once; pwm_match |=> !pwm_match; endproperty
  property p_zero; pwm_match |-> pwm_count == 8'h00; endproperty
  // Without a write, the count only steps up or wraps to zero.
  property p_step;
    $changed(pwm_count) && !$past(psel) |-> pwm_count == $past(pwm_count) + 8'h01 || pwm_count == 8'h00;
  endproperty
  // A tick is at least one instruction cycle, four clocks, apart.
  property p_gap;
    $changed(pwm_count) && !$past(psel) |=> ($stable(pwm_count) || $past(psel)) [*3];
  endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("no ready after setup");
  a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
  a_err: assert property (p_err) else $error("bad error answer");
  a_idle: assert property (p_idle) else $error("read data outside access");
  a_pair: assert property (p_pair) else $error("serial and pwm pulses differ");
  a_once: assert property (p_once) else $error("match pulse too long");
  a_zero: assert property (p_zero) else $error("count not zero at match");
  a_step: assert property (p_step) else $error("count jumped");
  a_gap: assert property (p_gap) else $error("ticks too close");
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
  c_match: cover property (pwm_match);
endmodule // ptmr_top_checker
bind ptmr_top ptmr_top_checker chk_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .ssp_shift_clk(ssp_shift_clk), .pwm_count(pwm_count),
  .pwm_match(pwm_match));
`default_nettype wire

// ### ptmr_partner.sv
// Purpose: Stand-in for the serial port and the PWM unit.
// Assumes: Samples the timer outputs on clk.
// Notes: Records pulse count, spacing and the count before each wrap.
`timescale 1ns/100ps
`default_nettype none
module ptmr_partner (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Timer outputs.
  input wire logic ssp_shift_clk,
  input wire logic pwm_match,
  input wire logic [7:0] pwm_count,
  // Observations.
  output logic [15:0] pulse_total,
  output logic [15:0] pulse_gap,
  output logic [7:0] pulse_top
);
  logic [15:0] since;
  logic [7:0] prev;
  // The gap is counted in clocks so the bench can judge the prescaler.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_total <= 16'h0;
      pulse_gap <= 16'h0;
      pulse_top <= 8'h0;
      since <= 16'h0;
      prev <= 8'h0;
    end else begin
      prev <= pwm_count;
      since <= ssp_shift_clk ? 16'h1 : since + 16'h1;
      if (ssp_shift_clk) pulse_gap <= since;
      if (pwm_match) pulse_total <= pulse_total + 16'h1;
      if (pwm_match) pulse_top <= prev;
    end
  end
endmodule // ptmr_partner
`default_nettype wire

// ### period_timer_8bit_test.sv
// Purpose: Self-checking bench for the period timer.
// Assumes: APB master on clk; partner model watches the outputs.
// Notes: Period 2 keeps each wrap to three prescaled ticks, twelve clocks at divide by one.
`timescale 1ns/100ps
`default_nettype none
`include "ptmr_map.vh"
module period_timer_8bit_test;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, ssp_shift_clk, pwm_match, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pwm_count, pulse_top;
  logic [15:0] pulse_total, pulse_gap;
  int fail_count, samples_checked;
  ptmr_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ssp_shift_clk(ssp_shift_clk), .pwm_count(pwm_count), .pwm_match(pwm_match));
  ptmr_partner far_i (.clk(clk), .rst(rst), .ssp_shift_clk(ssp_shift_clk), .pwm_match(pwm_match),
    .pwm_count(pwm_count), .pulse_total(pulse_total), .pulse_gap(pulse_gap), .pulse_top(pulse_top));
  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task final_report;
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Bounded wait for a match pulse or the interrupt line.
  task wait_hi(input logic which);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((which ? irq : pwm_match) !== 1'b1 && n < 4000);
    if (n >= 4000) chk(32'h0, 32'h1);
  endtask
  task t_reset;
    rdchk(`PTMR_OFS_COUNT, 32'h0);
    rdchk(`PTMR_OFS_CTRL, 32'h0);
    rdchk(`PTMR_OFS_PERIOD, 32'hff);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `PTMR_OFS_CTRL, 32'hff);
    rdchk(`PTMR_OFS_CTRL, 32'h7f);
    apb(1'b1, `PTMR_OFS_PERIOD, 32'h2);
    rdchk(`PTMR_OFS_PERIOD, 32'h2);
  endtask
  // Every prescale code; a wrap takes three ticks of four clocks times the ratio.
  task t_prescale;
    logic [1:0] p;
    for (int i = 0; i < 4; i++) begin
      p = i[1:0];
      apb(1'b1, `PTMR_OFS_CTRL, 32'h0);
      apb(1'b1, `PTMR_OFS_COUNT, 32'h0);
      apb(1'b1, `PTMR_OFS_CTRL, {29'h0, 1'b1, p});
      wait_hi(1'b0);
      wait_hi(1'b0);
      @(posedge clk);
      chk({16'h0, pulse_gap}, (i == 0) ? 32'd12 : (i == 1) ? 32'd48 : 32'd192);
      chk({24'h0, pulse_top}, 32'h2);
    end
  endtask
  task t_postscale;
    int ns[3];
    logic [3:0] n;
    logic [15:0] m;
    ns = '{0, 5, 15};
    for (int i = 0; i < 3; i++) begin
      n = ns[i][3:0];
      apb(1'b1, `PTMR_OFS_CTRL, 32'h0);
      apb(1'b1, `PTMR_OFS_COUNT, 32'h0);
      apb(1'b1, `PTMR_OFS_FLAG, 32'h2);
      apb(1'b1, `PTMR_OFS_ENABLE, 32'h2);
      m = pulse_total;
      apb(1'b1, `PTMR_OFS_CTRL, {25'h0, n, 3'b100});
      rdchk(`PTMR_OFS_CTRL, {25'h0, n, 3'b100});
      wait_hi(1'b1);
      @(posedge clk);
      chk({16'h0, pulse_total - m}, {28'h0, n} + 32'h1);
      apb(1'b1, `PTMR_OFS_CTRL, 32'h0);
      rdchk(`PTMR_OFS_FLAG, 32'h2);
      apb(1'b1, `PTMR_OFS_ENABLE, 32'h0);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(`PTMR_OFS_FLAG, 32'h2);
      apb(1'b1, `PTMR_OFS_FLAG, 32'h2);
      rdchk(`PTMR_OFS_FLAG, 32'h0);
    end
  endtask
  // A stopped timer keeps a written count through a control write.
  task t_hold;
    apb(1'b1, `PTMR_OFS_CTRL, 32'h0);
    apb(1'b1, `PTMR_OFS_COUNT, 32'h55);
    apb(1'b1, `PTMR_OFS_CTRL, 32'h3b);
    repeat (50) @(posedge clk);
    rdchk(`PTMR_OFS_COUNT, 32'h55);
  endtask
  // A reset in mid-run must clear a running count and restore the period.
  task t_rerun;
    apb(1'b1, `PTMR_OFS_PERIOD, 32'h40);
    apb(1'b1, `PTMR_OFS_CTRL, 32'h04);
    repeat (40) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(`PTMR_OFS_COUNT, 32'h0);
    rdchk(`PTMR_OFS_CTRL, 32'h0);
    rdchk(`PTMR_OFS_PERIOD, 32'hff);
    chk({31'h0, irq}, 32'h0);
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_prescale;
    t_postscale;
    t_hold;
    t_rerun;
    final_report;
  end
  // The whole run needs well under this many clocks.
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule // period_timer_8bit_test
`default_nettype wire
